// File: hw/cict_core.sv
/*
 * Instruction cycle timing core: fetches opcode and operand bytes, holds each
 * instruction for its documented cycle count, executes arithmetic, logical,
 * rotate, transfer and external-space moves, then advances the program counter.
 * Assumes code_data answers code_addr in the same cycle and all inputs are
 * synchronous to sys_clk.
 */
`timescale 1ns/1ns
module cict_core
   import cict_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // program fetch
   output logic [15:0] code_addr,
   input wire logic [7:0] code_data,
   // core configuration levels
   input wire logic [1:0] bank_sel,
   input wire logic flash_space_sel,
   // on-chip flash reached by the external-space move
   output logic [15:0] flash_addr,
   input wire logic [7:0] flash_rdata,
   output logic flash_wr,
   output logic [7:0] flash_wdata,
   // architectural state
   output logic [15:0] pc,
   output logic [7:0] acc,
   output logic carry,
   output logic [15:0] data_pointer,
   // completion report
   output logic instr_done,
   output logic [7:0] done_opcode,
   output logic [1:0] done_len,
   output logic [1:0] done_cycles,
   output logic bad_opcode
);

   // alu selection for a group nibble
   function automatic cict_alu_t grp_alu(input logic [3:0] hi);
      grp_alu = (hi == GRP_ADD) ? ALU_ADD : (hi == GRP_ADD_CY) ? ALU_ADD_CY :
         (hi == GRP_SUB_BW) ? ALU_SUB_BW : (hi == GRP_OR) ? ALU_OR :
         (hi == GRP_AND) ? ALU_AND : ALU_XOR;
   endfunction

   function automatic cict_alu_t rot_alu(input logic [3:0] hi);
      rot_alu = (hi == GRP_RR) ? ALU_RR : (hi == GRP_RRC) ? ALU_RRC :
         (hi == GRP_ADD) ? ALU_RL : ALU_RL_CY;
   endfunction

   // opcode to length, cycles and datapath steering
   function automatic cict_dec_t cict_decode(input logic [7:0] op);
      cict_dec_t d;
      logic [3:0] hi;
      logic [3:0] lo;
      cict_src_t m;
      logic [1:0] ml;
      logic [1:0] mc;
      logic arith;
      logic lgc;
      hi = op[7:4];
      lo = op[3:0];
      m = lo[3] ? SRC_REG : (lo[3:1] == LO_IND_HI) ? SRC_IND :
         (lo == LO_DIR) ? SRC_DIR : (lo == LO_IMM) ? SRC_IMM : SRC_NONE;
      ml = (m == SRC_DIR || m == SRC_IMM) ? LEN_2 : LEN_1;
      mc = (m == SRC_REG) ? CYC_1 : CYC_2;
      arith = (hi == GRP_ADD) || (hi == GRP_ADD_CY) || (hi == GRP_SUB_BW);
      lgc = (hi == GRP_OR) || (hi == GRP_AND) || (hi == GRP_XOR);
      d = '{LEN_1, CYC_1, ALU_NOP, SRC_NONE, DST_NONE, 1'b0};
      if ((arith || lgc) && m != SRC_NONE) begin
         d = '{ml, mc, grp_alu(hi), m, DST_A, 1'b1}; // [RULE3] [RULE4] [RULE5] [RULE6]
      end else if (lgc && lo == LO_DIR_A) begin
         d = '{LEN_2, CYC_2, grp_alu(hi), SRC_A, DST_DIR, 1'b1}; // [RULE9]
      end else if (lgc && lo == LO_DIR_IMM) begin
         d = '{LEN_3, CYC_3, grp_alu(hi), SRC_IMM, DST_DIR, 1'b1}; // [RULE10]
      end else if (hi <= GRP_ADD_CY && lo == LO_ROT) begin
         d = '{LEN_1, CYC_1, rot_alu(hi), SRC_NONE, DST_A, 1'b1}; // [RULE12]
      end else if (op == OPC_DP_LD) begin
         d = '{LEN_3, CYC_3, ALU_DPLD, SRC_IMM, DST_NONE, 1'b1};
      end else if (op == OPC_DP_INC) begin
         d = '{LEN_1, CYC_1, ALU_DPINC, SRC_NONE, DST_NONE, 1'b1};
      end else if (op == OPC_NOP || op == OPC_NOP_ALT) begin
         d.known = 1'b1;
      end else if ((hi == GRP_RDA || hi == GRP_WRA)
                   && (lo == LO_XS_DP || lo[3:1] == LO_XS_PTR)) begin
         d = '{LEN_1, CYC_3, (hi == GRP_RDA) ? ALU_XRD : ALU_XWR, SRC_NONE,
               (hi == GRP_RDA) ? DST_A : DST_NONE, 1'b1}; // [RULE1]
      end else if (hi == GRP_RDA && m != SRC_NONE && m != SRC_IMM) begin
         d = '{ml, mc, ALU_MOV, m, DST_A, 1'b1};
      end else if (hi == GRP_MOVI && m != SRC_NONE) begin
         d = '{(m == SRC_DIR) ? LEN_3 : LEN_2, (m == SRC_DIR) ? CYC_3 : CYC_2,
               ALU_MOV, SRC_IMM,
               (m == SRC_IMM) ? DST_A : (m == SRC_DIR) ? DST_DIR :
               (m == SRC_IND) ? DST_IND : DST_REG, 1'b1}; // [RULE15]
      end else if (hi == GRP_MOVD && m != SRC_NONE && m != SRC_IMM) begin
         d = '{(m == SRC_DIR) ? LEN_3 : LEN_2, (m == SRC_DIR) ? CYC_3 : CYC_2,
               ALU_MOV, m, DST_DIR, 1'b1}; // [RULE13] [RULE16] [RULE17]
      end else if (hi == GRP_MOVR && (m == SRC_IND || m == SRC_REG)) begin
         d = '{LEN_2, CYC_2, ALU_MOV, SRC_DIR,
               (m == SRC_IND) ? DST_IND : DST_REG, 1'b1}; // [RULE17]
      end else if (hi == GRP_WRA && m != SRC_NONE && m != SRC_IMM) begin
         d = '{(m == SRC_DIR) ? LEN_2 : LEN_1, mc, ALU_MOV, SRC_A,
               (m == SRC_DIR) ? DST_DIR : (m == SRC_IND) ? DST_IND : DST_REG,
               1'b1}; // [RULE14]
      end
      return d;
   endfunction

   // {carry, result}; carry passes through unless the operation defines it
   function automatic logic [8:0] cict_alu(input cict_alu_t f, input logic [7:0] a,
                                           input logic [7:0] b, input logic c);
      logic [8:0] r;
      r = {c, a};
      case (f)
         ALU_ADD: r = {1'b0, a} + {1'b0, b};
         ALU_ADD_CY: r = {1'b0, a} + {1'b0, b} + {8'h00, c}; // [RULE7] [RULE8]
         ALU_SUB_BW: r = {1'b0, a} - {1'b0, b} - {8'h00, c};
         ALU_OR: r = {c, a | b};
         ALU_AND: r = {c, a & b};
         ALU_XOR: r = {c, a ^ b};
         ALU_MOV: r = {c, b};
         ALU_RL: r = {c, a[6:0], a[7]};
         ALU_RL_CY: r = {a, c}; // [RULE12]
         ALU_RR: r = {c, a[0], a[7:1]};
         ALU_RRC: r = {a[0], c, a[7:1]};
         default: r = {c, a};
      endcase
      return r;
   endfunction

   logic [7:0] iram [IRAM_DEPTH];
   logic [7:0] aux_ram [AUX_DEPTH];
   logic [1:0] cyc;
   logic [7:0] op_q;
   logic [7:0] b1_q;
   logic xs_flash;
   logic [2:0] gap_cnt;
   cict_dec_t dec;
   cict_dec_t dec_q;

   // current opcode is live on the first cycle, held afterwards
   wire first = (cyc == IDX_OP);
   wire [7:0] cur_op = first ? code_data : op_q;
   assign dec = cict_decode(cur_op);
   assign dec_q = cict_decode(op_q);
   wire last = (cyc == dec.ncyc - CYC_1); // [RULE18]
   // fetch index uses the held opcode only, so no loop runs through the code memory
   wire [1:0] byte_idx = first ? IDX_OP : (cyc < dec_q.len) ? cyc : dec_q.len - LEN_1;
   assign code_addr = pc + {14'h0000, byte_idx};

   // operand bytes: the byte of the current cycle is taken straight from fetch
   wire [7:0] byte1 = (cyc == IDX_B1) ? code_data : b1_q;
   wire [7:0] imm = (dec.len == LEN_3) ? code_data : byte1;
   wire [7:0] bank_reg_addr = {BANK_PAD, bank_sel, cur_op[RSEL_W-1:0]};
   wire [7:0] ptr_reg_addr = {BANK_PAD, bank_sel, PTR_PAD, cur_op[0]};
   wire [7:0] ptr = iram[ptr_reg_addr];
   wire [7:0] dst_dir = (dec.src == SRC_DIR && dec.dst == DST_DIR) ? code_data : byte1;

   // operand selection
   wire [7:0] src_val = (dec.src == SRC_A) ? acc : (dec.src == SRC_REG) ? iram[bank_reg_addr] :
      (dec.src == SRC_DIR) ? iram[byte1] : (dec.src == SRC_IND) ? iram[ptr] :
      (dec.src == SRC_IMM) ? imm : 8'h00;
   wire [7:0] dst_val = (dec.dst == DST_REG) ? iram[bank_reg_addr] :
      (dec.dst == DST_DIR) ? iram[dst_dir] : (dec.dst == DST_IND) ? iram[ptr] : acc;
   wire [7:0] iram_waddr = (dec.dst == DST_REG) ? bank_reg_addr :
      (dec.dst == DST_IND) ? ptr : dst_dir;
   wire iram_we = last && (dec.dst == DST_REG || dec.dst == DST_DIR || dec.dst == DST_IND);

   // external-space move: only on-chip aux ram or flash answers, never a pin
   wire is_xs = (dec.alu == ALU_XRD) || (dec.alu == ALU_XWR);
   wire [15:0] xs_ptr = (cur_op[3:0] == LO_XS_DP) ? data_pointer : {XPAGE, ptr};
   wire [AUX_AW-1:0] aux_addr = flash_addr[AUX_AW-1:0]; // wraps on aux ram size [RULE2]
   wire [7:0] xs_rd = xs_flash ? flash_rdata : aux_ram[aux_addr]; // [RULE1]
   wire aux_we = last && dec.alu == ALU_XWR && !xs_flash; // [RULE1]

   wire [8:0] alu_out = cict_alu(dec.alu, dst_val, src_val, carry);
   wire [7:0] exec_res = (dec.alu == ALU_XRD) ? xs_rd : alu_out[7:0];

   // sequencing and architectural registers; commit happens on the last cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cyc <= IDX_OP;
         pc <= PC_RESET;
         op_q <= 8'h00;
         b1_q <= 8'h00;
         acc <= 8'h00;
         carry <= 1'b0;
         data_pointer <= 16'h0000;
         flash_addr <= 16'h0000;
         xs_flash <= 1'b0;
         flash_wr <= 1'b0;
         flash_wdata <= 8'h00;
         instr_done <= 1'b0;
         done_opcode <= 8'h00;
         done_len <= LEN_1;
         done_cycles <= CYC_1;
         bad_opcode <= 1'b0;
      end else begin
         instr_done <= last;
         flash_wr <= last && dec.alu == ALU_XWR && xs_flash; // [RULE1]
         if (first) begin
            op_q <= code_data;
         end
         if (cyc == IDX_B1) begin
            b1_q <= code_data;
         end
         // address and space are frozen for the remaining move cycles
         if (first && is_xs) begin
            flash_addr <= xs_ptr;
            xs_flash <= flash_space_sel;
         end
         if (last) begin
            cyc <= IDX_OP;
            pc <= pc + {14'h0000, dec.len}; // [RULE19]
            carry <= alu_out[8];
            done_opcode <= cur_op;
            done_len <= dec.len;
            done_cycles <= cyc + CYC_1;
            bad_opcode <= !dec.known;
            flash_wdata <= acc;
            if (dec.dst == DST_A) begin
               acc <= exec_res;
            end
            if (dec.alu == ALU_DPLD) begin
               data_pointer <= {byte1, code_data};
            end else if (dec.alu == ALU_DPINC) begin
               data_pointer <= data_pointer + 16'h0001;
            end
         end else begin
            cyc <= cyc + CYC_1;
         end
      end
   end

   // storage arrays carry no reset; software initialises them
   always_ff @(posedge sys_clk) begin
      if (!srst && iram_we) begin
         iram[iram_waddr] <= exec_res;
      end
      if (!srst && aux_we) begin
         aux_ram[aux_addr] <= acc;
      end
   end

   // checking helpers: independent cycle count between completions
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gap_cnt <= 3'h0;
      end else if (instr_done) begin
         gap_cnt <= 3'h1;
      end else if (gap_cnt != 3'h7) begin
         gap_cnt <= gap_cnt + 3'h1;
      end
   end

   wire [3:0] dhi = done_opcode[7:4];
   wire [3:0] dlo = done_opcode[3:0];
   wire h_arith = (dhi == GRP_ADD) || (dhi == GRP_ADD_CY) || (dhi == GRP_SUB_BW);
   wire h_logic = (dhi == GRP_OR) || (dhi == GRP_AND) || (dhi == GRP_XOR);
   wire h_ind = (dlo[3:1] == LO_IND_HI);
   wire h_xs = (dhi == GRP_RDA || dhi == GRP_WRA)
      && (dlo == LO_XS_DP || dlo[3:1] == LO_XS_PTR);
   logic [7:0] done_src;
   always_ff @(posedge sys_clk) begin
      done_src <= src_val;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_shape(logic hit, logic [1:0] l, logic [1:0] c);
      instr_done && hit |-> done_len == l && done_cycles == c;
   endproperty

   a_reg_arith: assert property (p_shape(h_arith && dlo[3], LEN_1, CYC_1)) // [RULE3]
      else $error("bank register arithmetic shape wrong");
   a_dir_arith: assert property (p_shape(h_arith && dlo == LO_DIR, LEN_2, CYC_2)) // [RULE4]
      else $error("direct arithmetic shape wrong");
   a_ind_arith: assert property (p_shape(h_arith && h_ind, LEN_1, CYC_2)) // [RULE5]
      else $error("indirect arithmetic shape wrong");
   a_imm_arith: assert property (p_shape(h_arith && dlo == LO_IMM, LEN_2, CYC_2)) // [RULE6]
      else $error("immediate arithmetic shape wrong");
   a_carry_sum: assert property (instr_done && dhi == GRP_ADD_CY && dlo >= LO_IMM // [RULE7]
      |-> acc == 8'($past(acc) + done_src + {7'h00, $past(carry)}))
      else $error("add with carry result ignores carry");
   a_carry_dir: assert property (p_shape(dhi == GRP_ADD_CY && dlo == LO_DIR, LEN_2, CYC_2)) // [RULE8]
      else $error("direct add with carry shape wrong");
   a_logic_dir: assert property (p_shape(h_logic && dlo == LO_DIR_A, LEN_2, CYC_2)) // [RULE9]
      else $error("logical into direct shape wrong");
   a_logic_imm: assert property (p_shape(h_logic && dlo == LO_DIR_IMM, LEN_3, CYC_3)) // [RULE10]
      else $error("logical immediate into direct shape wrong");
   a_logic_ind: assert property (p_shape(h_logic && h_ind, LEN_1, CYC_2)) // [RULE11]
      else $error("logical indirect shape wrong");
   a_rot_carry: assert property (instr_done && dhi == GRP_ADD_CY && dlo == LO_ROT // [RULE12]
      |-> done_cycles == CYC_1 && acc == {$past(acc[6:0]), $past(carry)}
          && carry == $past(acc[7]))
      else $error("rotate through carry wrong");
   a_dir_dir: assert property (p_shape(dhi == GRP_MOVD && dlo == LO_DIR, LEN_3, CYC_3)) // [RULE13]
      else $error("direct to direct move shape wrong");
   a_st_ind: assert property (p_shape(dhi == GRP_WRA && h_ind, LEN_1, CYC_2)) // [RULE14]
      else $error("accumulator indirect store shape wrong");
   a_imm_ind: assert property (p_shape(dhi == GRP_MOVI && h_ind, LEN_2, CYC_2)) // [RULE15]
      else $error("immediate indirect store shape wrong");
   a_ind_dir: assert property (p_shape(dhi == GRP_MOVD && h_ind, LEN_2, CYC_2)) // [RULE16]
      else $error("indirect to direct move shape wrong");
   a_reg_dir: assert property (p_shape((dhi == GRP_MOVD || dhi == GRP_MOVR) && dlo[3],
      LEN_2, CYC_2)) // [RULE17]
      else $error("bank register direct move shape wrong");
   a_span_count: assert property (instr_done |-> gap_cnt == {1'b0, done_cycles}) // [RULE18]
      else $error("measured cycles differ from reported");
   a_pc_step: assert property (instr_done |-> pc == $past(pc) + {14'h0000, done_len}) // [RULE19]
      else $error("program counter step wrong");
   a_flash_wr: assert property (flash_wr |-> instr_done && h_xs && xs_flash // [RULE1]
      && flash_wdata == acc)
      else $error("flash write outside flash move");
   a_xs_time: assert property (instr_done && h_xs |-> done_cycles == CYC_3 // [RULE2]
      && $past(flash_addr, 2) == flash_addr)
      else $error("external-space move timing or address unstable");

   c_carry_direct: cover property (instr_done && done_opcode == {GRP_ADD_CY, LO_DIR});
   c_flash_write: cover property (flash_wr);
   c_logic_imm: cover property (instr_done && h_logic && dlo == LO_DIR_IMM);
   c_back_to_back: cover property (instr_done ##1 instr_done);

endmodule

// File: hw/cict_pkg.sv
/*
 * Constants, opcode groups, decode types for the instruction cycle timing core.
 * Assumes a single 20 MHz system clock and on-chip code, data and aux storage only.
 */
// Contract
// RULE1: external-space move reaches aux RAM and flash
// RULE2: no off-chip memory path exists
// RULE3: bank-register add variants: one byte, one cycle
// RULE4: direct-operand arithmetic: two bytes, two cycles
// RULE5: pointer-indirect arithmetic: one byte, two cycles
// RULE6: immediate arithmetic: two bytes, two cycles
// RULE7: add_with_carry adds carry; indirect one/two
// RULE8: direct add_with_carry: two bytes, two cycles
// RULE9: logical op into direct byte: two/two
// RULE10: logical immediate into direct byte: three/three
// RULE11: logical pointer-indirect with accumulator: one/two
// RULE12: accumulator rotates: one byte, one cycle
// RULE13: direct to direct move: three/three
// RULE14: accumulator store via pointer: one/two
// RULE15: immediate store via pointer: two/two
// RULE16: pointer-addressed into direct byte: two/two
// RULE17: bank register to/from direct: two/two
// RULE18: timing counted purely in clock cycles
// RULE19: program counter advances by encoded length
package cict_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   // encoded lengths and cycle counts
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;
   localparam logic [1:0] CYC_3 = 2'h3;
   // byte position inside the current instruction
   localparam logic [1:0] IDX_OP = 2'h0;
   localparam logic [1:0] IDX_B1 = 2'h1;
   // opcode high nibble groups
   localparam logic [3:0] GRP_RR = 4'h0;
   localparam logic [3:0] GRP_RRC = 4'h1;
   localparam logic [3:0] GRP_ADD = 4'h2;
   localparam logic [3:0] GRP_ADD_CY = 4'h3;
   localparam logic [3:0] GRP_OR = 4'h4;
   localparam logic [3:0] GRP_AND = 4'h5;
   localparam logic [3:0] GRP_XOR = 4'h6;
   localparam logic [3:0] GRP_MOVI = 4'h7;
   localparam logic [3:0] GRP_MOVD = 4'h8;
   localparam logic [3:0] GRP_SUB_BW = 4'h9;
   localparam logic [3:0] GRP_MOVR = 4'hA;
   localparam logic [3:0] GRP_RDA = 4'hE;
   localparam logic [3:0] GRP_WRA = 4'hF;
   // opcode low nibble modes
   localparam logic [3:0] LO_XS_DP = 4'h0;
   localparam logic [2:0] LO_XS_PTR = 3'h1;
   localparam logic [3:0] LO_DIR_A = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [3:0] LO_ROT = 4'h3;
   localparam logic [3:0] LO_IMM = 4'h4;
   localparam logic [3:0] LO_DIR = 4'h5;
   localparam logic [2:0] LO_IND_HI = 3'h3;
   // whole opcodes
   localparam logic [7:0] OPC_NOP = 8'h00;
   localparam logic [7:0] OPC_NOP_ALT = 8'hA5;
   localparam logic [7:0] OPC_DP_LD = 8'h90;
   localparam logic [7:0] OPC_DP_INC = 8'hA3;
   // storage and address fields
   localparam int IRAM_DEPTH = 256;
   localparam int AUX_DEPTH = 512;
   localparam int AUX_AW = 9;
   localparam int RSEL_W = 3;
   localparam logic [2:0] BANK_PAD = 3'h0;
   localparam logic [1:0] PTR_PAD = 2'h0;
   localparam logic [7:0] XPAGE = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;

   typedef enum logic [3:0] {
      ALU_NOP, ALU_ADD, ALU_ADD_CY, ALU_SUB_BW, ALU_OR, ALU_AND, ALU_XOR, ALU_MOV,
      ALU_RL, ALU_RL_CY, ALU_RR, ALU_RRC, ALU_XRD, ALU_XWR, ALU_DPLD, ALU_DPINC
   } cict_alu_t;
   typedef enum logic [2:0] {SRC_NONE, SRC_A, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} cict_src_t;
   typedef enum logic [2:0] {DST_NONE, DST_A, DST_REG, DST_DIR, DST_IND} cict_dst_t;
   typedef struct packed {
      logic [1:0] len;
      logic [1:0] ncyc;
      cict_alu_t alu;
      cict_src_t src;
      cict_dst_t dst;
      logic known;
   } cict_dec_t;
endpackage

// File: bench/cict_mem_model.sv
/* Behavioural on-chip code and flash storage facing the timing core.
   Assumes the bench loads code bytes while the core is held in reset. */
`timescale 1ns/1ns
module cict_mem_model (
   // clock
   input wire logic sys_clk,
   // fetch side
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data,
   // flash side of the external-space move
   input wire logic [15:0] flash_addr,
   output logic [7:0] flash_rdata,
   input wire logic flash_wr,
   input wire logic [7:0] flash_wdata
);
   logic [7:0] code [256];
   logic [7:0] flash [256];
   // zero-latency reads; low byte only, so the model aliases every 256 bytes
   assign code_data = code[code_addr[7:0]];
   assign flash_rdata = flash[flash_addr[7:0]];
   // byte write on the one-cycle strobe
   always @(posedge sys_clk) begin
      if (flash_wr) begin
         flash[flash_addr[7:0]] <= flash_wdata;
      end
   end
endmodule

// File: bench/core_instruction_cycle_timing_test.sv
/* Self-checking bench: lengths, cycle counts, pc steps and results per form.
   Assumes on-chip storage only; each program is loaded while reset is held. */
`timescale 1ns/1ns
module core_instruction_cycle_timing_test;
   import cict_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] bank_sel = 2'h0;
   logic flash_space_sel = 1'b0;
   logic [15:0] code_addr, flash_addr, pc, data_pointer, exp_pc;
   logic [7:0] code_data, flash_rdata, flash_wdata, acc, done_opcode, ea;
   logic flash_wr, carry, instr_done, bad_opcode, ec;
   logic [1:0] done_len, done_cycles;
   logic [8:0] t;
   logic [7:0] i_op [64];
   logic [1:0] i_len [64];
   logic [1:0] i_cyc [64];
   int n_errors = 0;
   int num_checks = 0;
   int wp, ni, ix;
   // clock
   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   cict_core cict_core_i (.sys_clk(sys_clk), .srst(srst), .code_addr(code_addr),
      .code_data(code_data), .bank_sel(bank_sel), .flash_space_sel(flash_space_sel),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_wr(flash_wr),
      .flash_wdata(flash_wdata), .pc(pc), .acc(acc), .carry(carry),
      .data_pointer(data_pointer),
      .instr_done(instr_done), .done_opcode(done_opcode), .done_len(done_len),
      .done_cycles(done_cycles), .bad_opcode(bad_opcode));
   cict_mem_model cict_mem_model_i (.sys_clk(sys_clk), .code_addr(code_addr),
      .code_data(code_data), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
      .flash_wr(flash_wr), .flash_wdata(flash_wdata));
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
      num_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   // add, add with carry, subtract with borrow: {carry, result}
   function automatic logic [8:0] alu(input logic [3:0] g, input logic [7:0] a,
                                      input logic [7:0] b, input logic c);
      case (g)
         4'h2: alu = {1'b0, a} + {1'b0, b};
         4'h3: alu = {1'b0, a} + {1'b0, b} + {8'h00, c};
         default: alu = {1'b0, a} - {1'b0, b} - {8'h00, c};
      endcase
   endfunction
   task automatic put(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                      input logic [1:0] len, input logic [1:0] cyc);
      cict_mem_model_i.code[wp] = op;
      cict_mem_model_i.code[wp + 1] = b1;
      cict_mem_model_i.code[wp + 2] = b2;
      i_op[ni] = op;
      i_len[ni] = len;
      i_cyc[ni] = cyc;
      wp += int'(len);
      ni++;
   endtask
   // core held in reset while code is replaced; a no-op leads every program
   task automatic load_start();
      @(negedge sys_clk);
      srst = 1'b1;
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < 256; i++) cict_mem_model_i.code[i] = 8'h00;
      wp = 0;
      ni = 0;
      ix = 0;
      exp_pc = PC_RESET;
      put(8'h00, 8'h00, 8'h00, 2'h1, 2'h1);
   endtask
   // run one instruction; the first after release has no interval to judge
   task automatic step();
      int n;
      n = 0;
      if (ix == 0) srst = 1'b0;
      do begin
         @(posedge sys_clk);
         @(negedge sys_clk);
         n++;
      end while (instr_done !== 1'b1 && n < 20);
      exp_pc = exp_pc + 16'(i_len[ix]);
      chk(instr_done, 1'b1, "done");
      chk(done_opcode, i_op[ix], "opcode");
      chk(done_len, i_len[ix], "length");
      chk(done_cycles, i_cyc[ix], "cycles");
      if (ix != 0) chk(16'(n), 16'(i_cyc[ix]), "interval");
      chk(pc, exp_pc, "pc");
      // 0xC4 is the one opcode the bench uses that the core leaves unsupported
      chk(bad_opcode, 16'(i_op[ix] == 8'hC4), "supported");
      ix++;
   endtask
   task automatic t_arith();
      logic [3:0] grp [3] = '{4'h2, 4'h3, 4'h9};
      logic [3:0] lo [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
      logic [7:0] opnd [4] = '{8'hC0, 8'h05, 8'h05, 8'h30};
      load_start();
      bank_sel = 2'h1;
      put(8'h75, 8'h30, 8'h05, 2'h3, 2'h3);
      put(8'h78, 8'h30, 8'h00, 2'h2, 2'h2);
      for (int g = 0; g < 3; g++)
         for (int k = 0; k < 4; k++)
            put({grp[g], lo[k]}, (k == 0) ? 8'hC0 : 8'h30, 8'h00, (k < 2) ? 2'h2 : 2'h1,
                (k == 3) ? 2'h1 : 2'h2);
      ea = 8'h00;
      ec = 1'b0;
      repeat (3) step();
      for (int g = 0; g < 3; g++)
         for (int k = 0; k < 4; k++) begin
            step();
            t = alu(grp[g], ea, opnd[k], ec);
            {ec, ea} = t;
            chk(acc, ea, "sum");
            chk(carry, ec, "carry");
         end
   endtask
   task automatic t_logic();
      load_start();
      put(8'h74, 8'h5A, 8'h00, 2'h2, 2'h2);
      put(8'h75, 8'h31, 8'h0F, 2'h3, 2'h3);
      put(8'h78, 8'h31, 8'h00, 2'h2, 2'h2);
      put(8'h42, 8'h31, 8'h00, 2'h2, 2'h2);
      put(8'h53, 8'h31, 8'h3C, 2'h3, 2'h3);
      put(8'h63, 8'h31, 8'hFF, 2'h3, 2'h3);
      put(8'h52, 8'h31, 8'h00, 2'h2, 2'h2);
      put(8'h62, 8'h31, 8'h00, 2'h2, 2'h2);
      put(8'h46, 8'h00, 8'h00, 2'h1, 2'h2);
      put(8'h56, 8'h00, 8'h00, 2'h1, 2'h2);
      put(8'h66, 8'h00, 8'h00, 2'h1, 2'h2);
      put(8'h43, 8'h31, 8'h81, 2'h3, 2'h3);
      put(8'h46, 8'h00, 8'h00, 2'h1, 2'h2);
      repeat (10) step();
      chk(acc, 16'h005A, "or indirect");
      step();
      chk(acc, 16'h0018, "and indirect");
      step();
      chk(acc, 16'h0000, "xor indirect");
      repeat (2) step();
      chk(acc, 16'h0099, "or immediate into direct");
   endtask
   task automatic t_rot();
      logic [7:0] op [4] = '{8'h33, 8'h13, 8'h23, 8'h03};
      logic [7:0] wa [4] = '{8'h02, 8'h81, 8'h03, 8'h81};
      logic wc [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      load_start();
      put(8'h74, 8'h81, 8'h00, 2'h2, 2'h2);
      for (int i = 0; i < 4; i++) put(op[i], 8'h00, 8'h00, 2'h1, 2'h1);
      put(8'hC4, 8'h00, 8'h00, 2'h1, 2'h1);
      repeat (2) step();
      for (int i = 0; i < 4; i++) begin
         step();
         chk(acc, wa[i], "rotate");
         chk(carry, wc[i], "rotate carry");
      end
      step();
      chk(acc, 16'h0081, "unsupported opcode keeps accumulator");
   endtask
   task automatic t_move();
      load_start();
      put(8'h74, 8'hA7, 8'h00, 2'h2, 2'h2);
      put(8'h75, 8'h32, 8'h11, 2'h3, 2'h3);
      put(8'h78, 8'h40, 8'h00, 2'h2, 2'h2);
      put(8'hF6, 8'h00, 8'h00, 2'h1, 2'h2);
      put(8'h85, 8'h40, 8'h33, 2'h3, 2'h3);
      put(8'h76, 8'h2B, 8'h00, 2'h2, 2'h2);
      put(8'h86, 8'h34, 8'h00, 2'h2, 2'h2);
      put(8'hA8, 8'h32, 8'h00, 2'h2, 2'h2);
      put(8'h88, 8'h35, 8'h00, 2'h2, 2'h2);
      for (int i = 3; i < 6; i++) begin
         put(8'h54, 8'h00, 8'h00, 2'h2, 2'h2);
         put(8'h45, 8'(8'h30 + i), 8'h00, 2'h2, 2'h2);
      end
      repeat (12) step();
      chk(acc, 16'h00A7, "pointer store then direct copy");
      repeat (2) step();
      chk(acc, 16'h002B, "pointer immediate then copy");
      repeat (2) step();
      chk(acc, 16'h0011, "bank register round trip");
   endtask
   task automatic t_xs_move();
      load_start();
      flash_space_sel = 1'b1;
      put(8'h90, 8'h00, 8'h20, 2'h3, 2'h3);
      put(8'h74, 8'hC3, 8'h00, 2'h2, 2'h2);
      put(8'hF0, 8'h00, 8'h00, 2'h1, 2'h3);
      put(8'h74, 8'h00, 8'h00, 2'h2, 2'h2);
      put(8'hE0, 8'h00, 8'h00, 2'h1, 2'h3);
      put(8'h74, 8'h5E, 8'h00, 2'h2, 2'h2);
      put(8'hF0, 8'h00, 8'h00, 2'h1, 2'h3);
      put(8'h74, 8'h00, 8'h00, 2'h2, 2'h2);
      put(8'hE0, 8'h00, 8'h00, 2'h1, 2'h3);
      repeat (3) step();
      chk(data_pointer, 16'h0020, "pointer load");
      step();
      chk(flash_wr, 1'b1, "flash strobe");
      chk(flash_addr, 16'h0020, "flash address");
      chk(flash_wdata, 16'h00C3, "flash data");
      repeat (2) step();
      chk(acc, 16'h00C3, "flash read");
      flash_space_sel = 1'b0;
      repeat (2) step();
      chk(flash_wr, 1'b0, "aux write stays on chip");
      repeat (2) step();
      chk(acc, 16'h005E, "aux ram read");
   endtask
   // main sequence
   initial begin
      repeat (16) @(negedge sys_clk);
      t_arith();
      t_logic();
      t_rot();
      t_move();
      t_xs_move();
      summarize();
   end
   // watchdog, far beyond the fewer than two hundred cycles the scenarios need
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_errors++;
      summarize();
   end
endmodule
